// ==== rtl/bsp_regs.svh ====
// Named constants for the baseband serial ports: word layout, command bits, framing counts.
// Assumes nothing; included by bare name by every design file that needs a figure.
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH

// -----------------------------------------------------------------------------
// Word layout
// -----------------------------------------------------------------------------
`define BSP_WORD_BITS      16
`define BSP_SAMPLE_BITS    15
`define BSP_WORD_MSB       4'hf
`define BSP_FLAG_I         1'b1
`define BSP_FLAG_Q         1'b0
`define BSP_CTL_LAST_BIT   4'hf

// -----------------------------------------------------------------------------
// Command word bits
// -----------------------------------------------------------------------------
`define BSP_PAIR_SEL_BIT   12
`define BSP_RATE_SEL_BIT   10

// -----------------------------------------------------------------------------
// Receive framing, in master clock periods minus one
// -----------------------------------------------------------------------------
`define BSP_FRAME_LAST_2X  6'h3f
`define BSP_FRAME_LAST_4X  6'h1f

// -----------------------------------------------------------------------------
// Reset stretch toward the master clock domain, in system clock periods
// -----------------------------------------------------------------------------
`define BSP_RST_HOLD       5'h1f

// -----------------------------------------------------------------------------
// Master clock rates expected from the system, in kHz
// -----------------------------------------------------------------------------
`define BSP_MCLK_DIGITAL_KHZ 6220.8
`define BSP_MCLK_ANALOG_KHZ  5120.0

`endif

// ==== rtl/bsp_pkg.sv ====
// Types shared by the baseband serial port design files.
// Assumes the constants header is in the include path.
`include "bsp_regs.svh"

package bsp_pkg;

   // --------------------------------------------------------------------------
   // Sample and state types
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic [`BSP_SAMPLE_BITS-1:0] i;
      logic [`BSP_SAMPLE_BITS-1:0] q;
   } bsp_sample_t;

   typedef logic [`BSP_WORD_BITS-1:0] bsp_word_t;

   typedef enum logic {
      BSP_WORD_I,
      BSP_WORD_Q
   } bsp_phase_t;

   typedef enum logic {
      BSP_CTL_IDLE,
      BSP_CTL_SHIFT
   } bsp_ctl_state_t;

endpackage : bsp_pkg

// ==== rtl/bsp_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset; in_ready is a flop.
`timescale 1ns/1ps

module bsp_buf2 #(
   parameter int W = 30
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   logic [W-1:0] mem [2];
   logic         wr_ptr;
   logic         rd_ptr;
   logic [1:0]   count;

   wire       push       = in_valid & in_ready;
   wire       pop        = out_valid & out_ready;
   wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

   assign out_valid = count != 2'h0;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr   <= 1'b0;
         rd_ptr   <= 1'b0;
         count    <= 2'h0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count    <= next_count;
         in_ready <= next_count != 2'h2;
      end
   end

endmodule : bsp_buf2

// ==== rtl/bsp_xfer.sv ====
// Toggle-handshake word crossing between two unrelated clocks.
// Assumes the source holds nothing after a take; the word register stays stable until acknowledged.
`timescale 1ns/1ps

module bsp_xfer #(
   parameter int W = 16
) (
   input  wire logic         src_clk,
   input  wire logic         src_rst,
   input  wire logic         src_valid,
   input  wire logic [W-1:0] src_data,
   output logic              src_ready,
   input  wire logic         dst_clk,
   input  wire logic         dst_rst,
   input  wire logic         dst_ready,
   output logic              dst_valid,
   output logic [W-1:0]      dst_data
);

   logic         req;
   logic [W-1:0] hold;
   logic         ack_s1;
   logic         ack_s2;
   logic         req_s1;
   logic         req_s2;
   logic         ack;

   wire take = src_valid & src_ready;
   wire grab = (req_s2 != ack) & dst_ready;

   assign src_ready = req == ack_s2;

   // -----------------------------------------------------------------------------
   // Source side
   // -----------------------------------------------------------------------------
   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         req    <= 1'b0;
         hold   <= '0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack;
         ack_s2 <= ack_s1;
         if (take) begin
            req  <= ~req;
            hold <= src_data;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Destination side
   // -----------------------------------------------------------------------------
   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         req_s1    <= 1'b0;
         req_s2    <= 1'b0;
         ack       <= 1'b0;
         dst_valid <= 1'b0;
         dst_data  <= '0;
      end else begin
         req_s1    <= req;
         req_s2    <= req_s1;
         dst_valid <= grab;
         if (grab) begin
            ack      <= req_s2;
            dst_data <= hold;
         end
      end
   end

endmodule : bsp_xfer

// ==== rtl/bsp_top.sv ====
// Baseband serial ports: control word input, frame sync repeat, and I/Q receive output.
// Assumes clk is the system clock and mclk the master clock; link pins are timed to mclk.
`timescale 1ns/1ps
`include "bsp_regs.svh"

module bsp_top
   import bsp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        mclk,
   input  wire logic        sample_valid,
   input  wire bsp_sample_t sample,
   output logic             sample_ready,
   output logic             command_valid,
   output bsp_word_t        command_word,
   output logic             input_pair_select,
   output logic             sample_rate_select,
   input  wire logic        ctl_frame_in,
   input  wire logic        ctl_data_in,
   input  wire logic        repeat_enable_pin,
   output logic             serial_shift_clock,
   output logic             frame_repeat_out,
   output logic             frame_repeat_oe_n,
   output logic             receive_bit_clock,
   output logic             receive_frame_sync,
   output logic             receive_serial_output
);

   // -----------------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------------
   function automatic logic word_bit(input bsp_word_t w, input logic [3:0] idx);
      word_bit = w[`BSP_WORD_MSB - idx];
   endfunction : word_bit

   // -----------------------------------------------------------------------------
   // Reset into the master clock domain
   // -----------------------------------------------------------------------------
   logic [4:0] rst_hold_cnt;
   logic       rst_long;
   logic       mrst_s1;
   logic       mrst;

   // Stretches a short srst so that the slower master clock is sure to see it.
   always_ff @(posedge clk) begin
      if (srst) begin
         rst_hold_cnt <= `BSP_RST_HOLD;
         rst_long     <= 1'b1;
      end else begin
         rst_hold_cnt <= (rst_hold_cnt == 5'h00) ? 5'h00 : rst_hold_cnt - 5'h01;
         rst_long     <= rst_hold_cnt != 5'h00;
      end
   end

   always_ff @(posedge mclk) begin
      mrst_s1 <= rst_long;
      mrst    <= mrst_s1;
   end

   // -----------------------------------------------------------------------------
   // Sample path: buffer, then crossing into the master clock domain
   // -----------------------------------------------------------------------------
   logic        buf_valid;
   bsp_sample_t buf_data;
   logic        xfer_ready;
   logic        hold_valid;
   bsp_sample_t hold_data;
   logic        hold_full;
   bsp_sample_t hold;

   bsp_buf2 #(
      .W ($bits(bsp_sample_t))
   ) u_buf (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (sample_valid),
      .in_data   (sample),
      .in_ready  (sample_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (xfer_ready)
   );

   bsp_xfer #(
      .W ($bits(bsp_sample_t))
   ) u_sample_xfer (
      .src_clk   (clk),
      .src_rst   (srst),
      .src_valid (buf_valid),
      .src_data  (buf_data),
      .src_ready (xfer_ready),
      .dst_clk   (mclk),
      .dst_rst   (mrst),
      .dst_ready (~hold_full),
      .dst_valid (hold_valid),
      .dst_data  (hold_data)
   );

   // -----------------------------------------------------------------------------
   // Control word path: shifter on the master clock, crossing into the system clock
   // -----------------------------------------------------------------------------
   bsp_ctl_state_t ctl_state;
   logic [3:0]     ctl_count;
   logic [14:0]    ctl_shift;
   logic           ctl_done;
   bsp_word_t      ctl_word;
   logic           cmd_valid;
   bsp_word_t      cmd_word;

   wire       shift_rise = ~serial_shift_clock;
   wire       ctl_last   = ctl_count == `BSP_CTL_LAST_BIT;
   bsp_word_t next_ctl_word;
   assign next_ctl_word = {ctl_shift, ctl_data_in};

   always_ff @(posedge mclk) begin
      if (mrst) begin
         serial_shift_clock <= 1'b0;
      end else begin
         serial_shift_clock <= ~serial_shift_clock;
      end
   end

   always_ff @(posedge mclk) begin
      if (mrst) begin
         ctl_state <= BSP_CTL_IDLE;
         ctl_count <= 4'h0;
         ctl_shift <= 15'h0000;
         ctl_done  <= 1'b0;
         ctl_word  <= '0;
      end else begin
         ctl_done <= 1'b0;
         if (shift_rise) begin
            case (ctl_state)
               BSP_CTL_IDLE: begin
                  if (ctl_frame_in) begin
                     ctl_state <= BSP_CTL_SHIFT;
                     ctl_count <= 4'h1;
                     ctl_shift <= {14'h0000, ctl_data_in};
                  end
               end
               BSP_CTL_SHIFT: begin
                  ctl_shift <= next_ctl_word[14:0];
                  ctl_count <= ctl_count + 4'h1;
                  if (ctl_last) begin
                     ctl_state <= BSP_CTL_IDLE;
                     ctl_done  <= 1'b1;
                     ctl_word  <= next_ctl_word;
                  end
               end
               default: begin
                  ctl_state <= BSP_CTL_IDLE;
               end
            endcase
         end
      end
   end

   bsp_xfer #(
      .W (`BSP_WORD_BITS)
   ) u_cmd_xfer (
      .src_clk   (mclk),
      .src_rst   (mrst),
      .src_valid (ctl_done),
      .src_data  (ctl_word),
      .src_ready (),
      .dst_clk   (clk),
      .dst_rst   (rst_long),
      .dst_ready (1'b1),
      .dst_valid (cmd_valid),
      .dst_data  (cmd_word)
   );

   // -----------------------------------------------------------------------------
   // Command outputs and mode bits in the system clock domain
   // -----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         command_valid      <= 1'b0;
         command_word       <= '0;
         input_pair_select  <= 1'b0;
         sample_rate_select <= 1'b0;
      end else begin
         command_valid <= cmd_valid;
         if (cmd_valid) begin
            command_word       <= cmd_word;
            input_pair_select  <= cmd_word[`BSP_PAIR_SEL_BIT];
            sample_rate_select <= cmd_word[`BSP_RATE_SEL_BIT];
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Frame sync repeat
   // -----------------------------------------------------------------------------
   logic rep_en_s1;
   logic rep_en_s2;

   always_ff @(posedge mclk) begin
      if (mrst) begin
         rep_en_s1         <= 1'b0;
         rep_en_s2         <= 1'b0;
         frame_repeat_out  <= 1'b0;
         frame_repeat_oe_n <= 1'b1;
      end else begin
         rep_en_s1         <= repeat_enable_pin;
         rep_en_s2         <= rep_en_s1;
         frame_repeat_out  <= ctl_frame_in;
         frame_repeat_oe_n <= ~rep_en_s2;
      end
   end

   // -----------------------------------------------------------------------------
   // Receive timing on the master clock
   // -----------------------------------------------------------------------------
   logic       rate_s1;
   logic       rate_s2;
   logic       rate_act;
   logic [5:0] cnt;

   wire [5:0] cnt_last       = rate_act ? `BSP_FRAME_LAST_4X : `BSP_FRAME_LAST_2X;
   wire [5:0] next_cnt       = (cnt >= cnt_last) ? 6'h00 : cnt + 6'h01;
   wire       next_half      = rate_act ? next_cnt[0] : next_cnt[1];
   wire [3:0] next_bit       = rate_act ? next_cnt[4:1] : next_cnt[5:2];
   wire       next_bit_start = rate_act ? ~next_cnt[0] : (next_cnt[1:0] == 2'b00);
   wire       word_start     = next_cnt == 6'h00;

   // -----------------------------------------------------------------------------
   // Receive word assembly
   // -----------------------------------------------------------------------------
   bsp_phase_t  phase;
   bsp_sample_t cur;
   bsp_word_t   tx_word;

   wire         take_sample = word_start & (phase == BSP_WORD_I) & hold_full;
   bsp_sample_t next_cur;
   bsp_word_t   next_word;
   bsp_word_t   bit_src;

   assign next_cur  = take_sample ? hold : cur;
   assign next_word = (phase == BSP_WORD_I) ? {next_cur.i, `BSP_FLAG_I}
                                            : {cur.q, `BSP_FLAG_Q};
   assign bit_src   = word_start ? next_word : tx_word;

   always_ff @(posedge mclk) begin
      if (mrst) begin
         hold_full <= 1'b0;
         hold      <= '0;
      end else begin
         if (hold_valid) begin
            hold_full <= 1'b1;
            hold      <= hold_data;
         end else if (take_sample) begin
            hold_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      // A rate change applies at a word boundary, so no bit or frame is cut short.
      // The counter leaves reset at its last count, so the first edge opens a whole word.
      if (mrst) begin
         rate_s1  <= 1'b0;
         rate_s2  <= 1'b0;
         rate_act <= 1'b0;
         cnt      <= `BSP_FRAME_LAST_2X;
      end else begin
         rate_s1 <= sample_rate_select;
         rate_s2 <= rate_s1;
         cnt     <= next_cnt;
         if (word_start) begin
            rate_act <= rate_s2;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (mrst) begin
         receive_bit_clock  <= 1'b0;
         receive_frame_sync <= 1'b0;
      end else begin
         receive_bit_clock  <= ~next_half;
         receive_frame_sync <= next_bit == 4'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (mrst) begin
         phase                 <= BSP_WORD_I;
         cur                   <= '0;
         tx_word               <= '0;
         receive_serial_output <= 1'b0;
      end else begin
         if (word_start) begin
            cur     <= next_cur;
            tx_word <= next_word;
            phase   <= (phase == BSP_WORD_I) ? BSP_WORD_Q : BSP_WORD_I;
         end
         if (next_bit_start) begin
            receive_serial_output <= word_bit(bit_src, next_bit);
         end
      end
   end

endmodule : bsp_top

// ==== testbench/bsp_props.sv ====
// Checker for the baseband serial ports, bound to bsp_top.
// Assumes the link logic is running 96 clk cycles after srst falls.
`timescale 1ns/1ps

module bsp_props
   import bsp_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        mclk,
   input wire logic        sample_valid,
   input wire bsp_sample_t sample,
   input wire logic        sample_ready,
   input wire logic        command_valid,
   input wire bsp_word_t   command_word,
   input wire logic        input_pair_select,
   input wire logic        sample_rate_select,
   input wire logic        ctl_frame_in,
   input wire logic        ctl_data_in,
   input wire logic        repeat_enable_pin,
   input wire logic        serial_shift_clock,
   input wire logic        frame_repeat_out,
   input wire logic        frame_repeat_oe_n,
   input wire logic        receive_bit_clock,
   input wire logic        receive_frame_sync,
   input wire logic        receive_serial_output
);
   // ------------------------------------------------------------------
   // Run and rate-steady counters
   // ------------------------------------------------------------------
   logic [7:0] run_cnt;
   logic [6:0] st_cnt;
   logic       rate_q;
   wire        run = (run_cnt == 8'h60);
   wire        st0 = run && (st_cnt == 7'h7f) && !rate_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         run_cnt <= 8'h00;
      end else if (!run) begin
         run_cnt <= run_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      rate_q <= sample_rate_select;
      if (srst || !run || (rate_q != sample_rate_select)) begin
         st_cnt <= 7'h0;
      end else if (st_cnt != 7'h7f) begin
         st_cnt <= st_cnt + 7'h1;
      end
   end

   AST_SHIFT_TOGGLE: assert property (@(posedge mclk) disable iff (srst)
      run |-> serial_shift_clock != $past(serial_shift_clock))
      else $error("shift clock did not toggle");
   AST_REPEAT_COPY: assert property (@(posedge mclk) disable iff (srst)
      run && !frame_repeat_oe_n |-> frame_repeat_out == $past(ctl_frame_in))
      else $error("frame repeat is not a copy of frame input");
   AST_REPEAT_ON: assert property (@(posedge mclk) disable iff (srst)
      (run && repeat_enable_pin)[*4] |-> !frame_repeat_oe_n)
      else $error("frame repeat not driven while enabled");
   AST_REPEAT_OFF: assert property (@(posedge mclk) disable iff (srst)
      (run && !repeat_enable_pin)[*4] |-> frame_repeat_oe_n)
      else $error("frame repeat driven while disabled");
   AST_PAIR_SEL: assert property (@(posedge clk) disable iff (srst)
      command_valid |-> input_pair_select == command_word[12])
      else $error("pair select does not follow bit 12");
   AST_RATE_SEL: assert property (@(posedge clk) disable iff (srst)
      command_valid |-> sample_rate_select == command_word[10])
      else $error("rate select does not follow bit 10");
   AST_BIT_CLK_2X: assert property (@(posedge mclk) disable iff (srst)
      $rose(receive_bit_clock) && st0 |-> $past(receive_bit_clock, 3)
      && $past(receive_bit_clock, 4) && !$past(receive_bit_clock, 2)
      && !$past(receive_bit_clock, 5))
      else $error("bit clock not four periods per bit");
   AST_FRAME_2X: assert property (@(posedge mclk) disable iff (srst)
      $rose(receive_frame_sync) && st0 |-> $past(receive_frame_sync, 64)
      && !$past(receive_frame_sync, 65) && $past(receive_frame_sync, 61)
      && !$past(receive_frame_sync, 60))
      else $error("frame sync period or width wrong");
   AST_DATA_HOLD: assert property (@(posedge mclk) disable iff (srst)
      run && !$rose(receive_bit_clock) |-> $stable(receive_serial_output))
      else $error("receive data changed away from bit clock rise");
   AST_FRAME_ALIGN: assert property (@(posedge mclk) disable iff (srst)
      run && $rose(receive_frame_sync) |-> $rose(receive_bit_clock))
      else $error("frame sync not aligned to bit clock rise");
endmodule : bsp_props

bind bsp_top bsp_props u_props (.clk, .srst, .mclk, .sample_valid, .sample, .sample_ready,
   .command_valid, .command_word, .input_pair_select, .sample_rate_select, .ctl_frame_in,
   .ctl_data_in, .repeat_enable_pin, .serial_shift_clock, .frame_repeat_out,
   .frame_repeat_oe_n, .receive_bit_clock, .receive_frame_sync, .receive_serial_output);

// ==== testbench/bsp_dsp_model.sv ====
// DSP-side model: shifts control words in and captures receive words.
// Assumes mclk and the shift clock are those seen at the device pins.
`timescale 1ns/1ps

module bsp_dsp_model
   import bsp_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       serial_shift_clock,
   input  wire logic       go,
   input  wire bsp_word_t  word,
   output logic            ctl_frame_in = 1'b0,
   output logic            ctl_data_in = 1'b0,
   input  wire logic       receive_bit_clock,
   input  wire logic       receive_frame_sync,
   input  wire logic       receive_serial_output,
   output bsp_word_t       rx_word = 16'h0000,
   output logic [15:0]     rx_cnt = 16'h0000
);
   bsp_word_t  sh = 16'h0000;
   bsp_word_t  rsh = 16'h0000;
   logic [4:0] n = 5'h0;
   logic [4:0] rn = 5'h0;
   logic       taken = 1'b0;

   // Changes after the edge where the shift clock is high, so the device samples on its rise.
   always @(posedge mclk) begin
      if (!go) begin
         taken <= 1'b0;
      end
      if (serial_shift_clock) begin
         if (n != 5'h0) begin
            ctl_frame_in <= 1'b0;
            ctl_data_in  <= sh[15];
            sh           <= sh << 1;
            n            <= n - 5'h1;
         end else if (go && !taken) begin
            ctl_frame_in <= 1'b1;
            ctl_data_in  <= word[15];
            sh           <= word << 1;
            n            <= 5'hf;
            taken        <= 1'b1;
         end else begin
            ctl_frame_in <= 1'b0;
            ctl_data_in  <= ~ctl_data_in;
         end
      end
   end

   // Captures on the bit clock fall, where receive data is valid.
   always @(negedge receive_bit_clock) begin
      rsh = {rsh[14:0], receive_serial_output};
      rn = receive_frame_sync ? 5'h1 : ((rn != 5'h0) ? rn + 5'h1 : 5'h0);
      if (rn == 5'h10) begin
         rx_word <= rsh;
         rx_cnt  <= rx_cnt + 16'h1;
         rn = 5'h0;
      end
   end
endmodule : bsp_dsp_model

// ==== testbench/baseband_serial_ports_tb_top.sv ====
// Self-checking bench for the baseband serial ports.
// Assumes the DSP model file and the bound checker are compiled alongside.
`timescale 1ns/1ps

module baseband_serial_ports_tb_top
   import bsp_pkg::*;
;
   logic        clk = 1'b0;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        sample_valid = 1'b0;
   bsp_sample_t sample = '0;
   logic        repeat_enable_pin = 1'b0;
   logic        go = 1'b0;
   bsp_word_t   word = 16'h0000;
   bsp_word_t   command_word, rx_word;
   logic [15:0] rx_cnt;
   logic        sample_ready, command_valid, input_pair_select, sample_rate_select;
   logic        ctl_frame_in, ctl_data_in, serial_shift_clock;
   logic        frame_repeat_out, frame_repeat_oe_n;
   logic        receive_bit_clock, receive_frame_sync, receive_serial_output;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   bsp_sample_t q[$];

   always #4 clk = ~clk;
   initial begin
      #3;
      forever #24 mclk = ~mclk;
   end

   bsp_top uut (.clk, .srst, .mclk, .sample_valid, .sample, .sample_ready, .command_valid,
      .command_word, .input_pair_select, .sample_rate_select, .ctl_frame_in, .ctl_data_in,
      .repeat_enable_pin, .serial_shift_clock, .frame_repeat_out, .frame_repeat_oe_n,
      .receive_bit_clock, .receive_frame_sync, .receive_serial_output);
   bsp_dsp_model dsp (.mclk, .serial_shift_clock, .go, .word, .ctl_frame_in, .ctl_data_in,
      .receive_bit_clock, .receive_frame_sync, .receive_serial_output, .rx_word, .rx_cnt);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic send_ctl(input bsp_word_t w);
      int k;
      word = w;
      go = 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (command_valid !== 1'b1 && k < 400);
      check(command_valid, 1'b1);
      check(command_word, w);
      check(input_pair_select, w[12]);
      check(sample_rate_select, w[10]);
      go = 1'b0;
      repeat (200) @(negedge clk);
   endtask : send_ctl

   task automatic fill;
      int k;
      for (k = 0; k < 12; k++) begin
         @(negedge clk);
         if (sample_ready !== 1'b1) break;
         sample = {15'h1230 + 15'(k), 15'h4560 + 15'(k)};
         sample_valid = 1'b1;
         q.push_back(sample);
      end
      sample_valid = 1'b0;
      check(sample_ready, 1'b0);
   endtask : fill

   task automatic get_word(output bsp_word_t w);
      logic [15:0] c;
      int k;
      c = rx_cnt;
      k = 0;
      while (rx_cnt === c && k < 2000) begin
         @(negedge clk);
         k++;
      end
      w = rx_word;
   endtask : get_word

   task automatic drain;
      bsp_word_t   w;
      bsp_sample_t s;
      int          k;
      s = q.pop_front();
      k = 0;
      do begin
         get_word(w);
         k++;
      end while (w !== {s.i, 1'b1} && k < 12);
      check(w, {s.i, 1'b1});
      while (1) begin
         get_word(w);
         check(w, {s.q, 1'b0});
         if (q.size() == 0) break;
         s = q.pop_front();
         get_word(w);
         check(w, {s.i, 1'b1});
      end
      get_word(w);
      check(w, {s.i, 1'b1});
   endtask : drain

   initial begin
      repeat (6) @(negedge clk);
      check(sample_ready, 1'b1);
      srst = 1'b0;
      repeat (120) @(negedge clk);
      check(frame_repeat_oe_n, 1'b1);
      repeat_enable_pin = 1'b1;
      repeat (40) @(negedge clk);
      check(frame_repeat_oe_n, 1'b0);
      send_ctl(16'h1400);
      send_ctl(16'h1000);
      send_ctl(16'h0400);
      repeat (800) @(negedge clk);
      send_ctl(16'h0000);
      fill();
      drain();
      repeat_enable_pin = 1'b0;
      repeat (40) @(negedge clk);
      check(frame_repeat_oe_n, 1'b1);
      close_out();
   end
endmodule : baseband_serial_ports_tb_top
